// ### ofs_pkg.sv
// Constants and types for the output terminal function select block
package ofs_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int PULSE_MAX_HZ = 100_000;
  localparam int PULSE_MIN_HALF = (CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
  localparam int PLC_PULSE_MS = 250;
  localparam int PLC_PULSE_CYC = (CLK_HZ / 1000) * PLC_PULSE_MS;
  localparam int AW = 8;
  localparam int FW = 6;
  localparam int HW = 16;
  localparam logic [AW-1:0] ADDR_MODE = 8'h00;
  localparam logic [AW-1:0] ADDR_SW_SEL = 8'h04;
  localparam logic [AW-1:0] ADDR_RELAY_SEL = 8'h08;
  localparam logic [AW-1:0] ADDR_OC2_SEL = 8'h0C;
  localparam logic [AW-1:0] ADDR_HALF = 8'h10;
  localparam logic [AW-1:0] ADDR_COMM = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h18;
  localparam int MODE_BIT = 0;
  localparam int COMM_SW = 0;
  localparam int COMM_RELAY = 1;
  localparam int COMM_OC2 = 2;
  localparam logic MODE_RST = 1'b0;
  localparam logic [FW-1:0] SW_SEL_RST = 6'h00;
  localparam logic [FW-1:0] RELAY_SEL_RST = 6'h02;
  localparam logic [FW-1:0] OC2_SEL_RST = 6'h00;
  localparam logic [HW-1:0] HALF_RST = 16'h00C8;
  localparam logic [2:0] COMM_RST = 3'h0;
  localparam logic [FW-1:0] FN_MAX = 6'h2A;
  localparam logic [FW-1:0] FN_NONE = 6'h00;
  localparam logic [FW-1:0] FN_RUN = 6'h01;
  localparam logic [FW-1:0] FN_FAULT = 6'h02;
  localparam logic [FW-1:0] FN_FREQUENCY_LEVEL_DETECT_ONE = 6'h03;
  localparam logic [FW-1:0] FN_ARRIVE = 6'h04;
  localparam logic [FW-1:0] FN_ZERO = 6'h05;
  localparam logic [FW-1:0] FN_MOT_OVL = 6'h06;
  localparam logic [FW-1:0] FN_DRV_OVL = 6'h07;
  localparam logic [FW-1:0] FN_CNT_SET = 6'h08;
  localparam logic [FW-1:0] FN_CNT_SPEC = 6'h09;
  localparam logic [FW-1:0] FN_LEN = 6'h0A;
  localparam logic [FW-1:0] FN_PLC = 6'h0B;
  localparam logic [FW-1:0] FN_RUNTIME = 6'h0C;
  localparam logic [FW-1:0] FN_FLIMIT = 6'h0D;
  localparam logic [FW-1:0] FN_TORQUE = 6'h0E;
  localparam logic [FW-1:0] FN_READY = 6'h0F;
  localparam logic [FW-1:0] FN_AI_GT = 6'h10;
  localparam logic [FW-1:0] FN_UPPER = 6'h11;
  localparam logic [FW-1:0] FN_LOWER = 6'h12;
  localparam logic [FW-1:0] FN_UNDERV = 6'h13;
  localparam logic [FW-1:0] FN_COMM = 6'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic running;
    logic freq_zero;
    logic fault_stop;
    logic frequency_level_detect_one;
    logic freq_arrive;
    logic motor_ovl_pre;
    logic drive_ovl_pre;
    logic cnt_set_hit;
    logic cnt_spec_hit;
    logic len_over;
    logic plc_cycle_done;
    logic run_time_over;
    logic set_beyond_lim;
    logic out_at_lim;
    logic speed_mode;
    logic torque_at_lim;
    logic stall;
    logic supply_ok;
    logic fault_seen;
    logic operable;
    logic upper_hit;
    logic lower_hit;
    logic under_volt;
  } ofs_cond_t;
endpackage : ofs_pkg

// ### ofs_top.sv
// Output terminal function select with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Mode 0 pulse, mode 1 switch; reset 0
// - Pulse frequency never above 100 kHz
// - Switch mode follows its own selector
// - Three selectors, codes 0-42, resets 0,2,0
// - Code 0 off; code 1 while running
// - Code 2 on fault stop
// - Codes 3, 4 level and arrival detection
// - Code 5 running at zero frequency
// - Code 6 motor overload pre-alarm
// - Code 7 drive overload pre-alarm
// - Codes 8, 9 count values reached
// - Code 10 length exceeds target
// - Code 11 one 250 ms pulse per cycle
// - Code 12 running time limit exceeded
// - Code 13 frequency at its limit
// - Code 14 torque limit in stall
// - Code 15 drive ready to operate
// - Code 16 first analog above second
// - Codes 17, 18 upper, lower limit reached; 18 only while running
// - Code 19 under-voltage state
// - Code 20 level commanded by host
module ofs_top #(
  parameter int AIW = 12,
  parameter int PLC_CYC = ofs_pkg::PLC_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ofs_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ofs_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ofs_pkg::ofs_cond_t cond,
  input wire logic [AIW-1:0] analog_input_one,
  input wire logic [AIW-1:0] analog_input_two,
  output logic multiplexed_output_terminal,
  output logic relay_output,
  output logic second_open_collector_output
);
  localparam int PCW = $clog2(PLC_CYC + 1);

  logic rst_meta_n;
  logic srst_n;
  logic terminal_mode_selector;
  logic [ofs_pkg::FW-1:0] switch_terminal_function_select;
  logic [ofs_pkg::FW-1:0] relay_function_select;
  logic [ofs_pkg::FW-1:0] second_oc_function_select;
  logic [ofs_pkg::HW-1:0] pulse_half;
  logic [ofs_pkg::HW-1:0] pulse_cnt;
  logic [2:0] comm_lvl;
  logic pulse_mode_terminal;
  logic switch_mode_terminal;
  logic next_switch;
  logic next_relay;
  logic next_oc2;
  logic plc_pulse;
  logic [PCW-1:0] plc_cnt;
  logic ai_gt;
  logic aw_held;
  logic w_held;
  logic [ofs_pkg::AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_mux;
  logic rd_ok;

  // Reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      srst_n <= rst_meta_n;
    end
  end

  // Selectors above the top code are refused, old code kept
  function automatic logic code_ok(input logic [31:0] d);
    code_ok = (d[31:ofs_pkg::FW] == '0) && (d[ofs_pkg::FW-1:0] <= ofs_pkg::FN_MAX);
  endfunction : code_ok

  function automatic logic mapped(input logic [ofs_pkg::AW-1:0] a);
    unique case (a)
      ofs_pkg::ADDR_MODE, ofs_pkg::ADDR_SW_SEL, ofs_pkg::ADDR_RELAY_SEL,
      ofs_pkg::ADDR_OC2_SEL, ofs_pkg::ADDR_HALF, ofs_pkg::ADDR_COMM,
      ofs_pkg::ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // Function code to level, shared by all three outputs
  function automatic logic pick(
    input logic [ofs_pkg::FW-1:0] code,
    input ofs_pkg::ofs_cond_t c,
    input logic plc,
    input logic gt,
    input logic host
  );
    case (code)
      ofs_pkg::FN_RUN: pick = c.running;
      ofs_pkg::FN_FAULT: pick = c.fault_stop;
      ofs_pkg::FN_FREQUENCY_LEVEL_DETECT_ONE: pick = c.frequency_level_detect_one;
      ofs_pkg::FN_ARRIVE: pick = c.freq_arrive;
      ofs_pkg::FN_ZERO: pick = c.running & c.freq_zero;
      ofs_pkg::FN_MOT_OVL: pick = c.motor_ovl_pre;
      ofs_pkg::FN_DRV_OVL: pick = c.drive_ovl_pre;
      ofs_pkg::FN_CNT_SET: pick = c.cnt_set_hit;
      ofs_pkg::FN_CNT_SPEC: pick = c.cnt_spec_hit;
      ofs_pkg::FN_LEN: pick = c.len_over;
      ofs_pkg::FN_PLC: pick = plc;
      ofs_pkg::FN_RUNTIME: pick = c.run_time_over;
      ofs_pkg::FN_FLIMIT: pick = c.set_beyond_lim & c.out_at_lim;
      ofs_pkg::FN_TORQUE: pick = c.speed_mode & c.torque_at_lim & c.stall;
      ofs_pkg::FN_READY: pick = c.supply_ok & ~c.fault_seen & c.operable;
      ofs_pkg::FN_AI_GT: pick = gt;
      ofs_pkg::FN_UPPER: pick = c.upper_hit;
      ofs_pkg::FN_LOWER: pick = c.lower_hit & c.running;
      ofs_pkg::FN_UNDERV: pick = c.under_volt;
      ofs_pkg::FN_COMM: pick = host;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  // Write channel: address and data taken in either order
  assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
  assign do_write = ce & aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ofs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? ofs_pkg::RESP_OKAY : ofs_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      terminal_mode_selector <= ofs_pkg::MODE_RST;
      switch_terminal_function_select <= ofs_pkg::SW_SEL_RST;
      relay_function_select <= ofs_pkg::RELAY_SEL_RST;
      second_oc_function_select <= ofs_pkg::OC2_SEL_RST;
      pulse_half <= ofs_pkg::HALF_RST;
      comm_lvl <= ofs_pkg::COMM_RST;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        ofs_pkg::ADDR_MODE: terminal_mode_selector <= w_data[ofs_pkg::MODE_BIT];
        ofs_pkg::ADDR_SW_SEL: if (code_ok(w_data)) begin
          switch_terminal_function_select <= w_data[ofs_pkg::FW-1:0];
        end
        ofs_pkg::ADDR_RELAY_SEL: if (code_ok(w_data)) begin
          relay_function_select <= w_data[ofs_pkg::FW-1:0];
        end
        ofs_pkg::ADDR_OC2_SEL: if (code_ok(w_data)) begin
          second_oc_function_select <= w_data[ofs_pkg::FW-1:0];
        end
        // Clamped so the pulse rate cannot pass its ceiling
        ofs_pkg::ADDR_HALF: if (w_strb[1]) begin
          pulse_half <= (w_data[ofs_pkg::HW-1:0] < ofs_pkg::HW'(ofs_pkg::PULSE_MIN_HALF)) ?
                        ofs_pkg::HW'(ofs_pkg::PULSE_MIN_HALF) : w_data[ofs_pkg::HW-1:0];
        end
        ofs_pkg::ADDR_COMM: comm_lvl <= w_data[2:0];
        default: ;
      endcase
    end
  end

  // Read channel, data from flops one cycle after the address
  assign s_axi_arready = ce & ~s_axi_rvalid;

  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ofs_pkg::ADDR_MODE: rd_mux[ofs_pkg::MODE_BIT] = terminal_mode_selector;
      ofs_pkg::ADDR_SW_SEL: rd_mux[ofs_pkg::FW-1:0] = switch_terminal_function_select;
      ofs_pkg::ADDR_RELAY_SEL: rd_mux[ofs_pkg::FW-1:0] = relay_function_select;
      ofs_pkg::ADDR_OC2_SEL: rd_mux[ofs_pkg::FW-1:0] = second_oc_function_select;
      ofs_pkg::ADDR_HALF: rd_mux[ofs_pkg::HW-1:0] = pulse_half;
      ofs_pkg::ADDR_COMM: rd_mux[2:0] = comm_lvl;
      ofs_pkg::ADDR_STATUS: rd_mux[4:0] = {plc_pulse, second_open_collector_output,
                                           relay_output, switch_mode_terminal,
                                           pulse_mode_terminal};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ofs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? ofs_pkg::RESP_OKAY : ofs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Square wave; half period never below the 100 kHz limit
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      pulse_cnt <= '0;
      pulse_mode_terminal <= 1'b0;
    end else if (ce) begin
      if (terminal_mode_selector) begin
        pulse_cnt <= '0;
        pulse_mode_terminal <= 1'b0;
      end else if (pulse_cnt >= pulse_half - 16'h0001) begin
        pulse_cnt <= '0;
        pulse_mode_terminal <= ~pulse_mode_terminal;
      end else begin
        pulse_cnt <= pulse_cnt + 16'h0001;
      end
    end
  end

  // One-shot per sequencer cycle; a new cycle restarts it
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      plc_cnt <= '0;
      plc_pulse <= 1'b0;
    end else if (ce) begin
      if (cond.plc_cycle_done) begin
        plc_cnt <= PCW'(PLC_CYC - 1);
        plc_pulse <= 1'b1;
      end else if (plc_cnt != '0) begin
        plc_cnt <= plc_cnt - PCW'(1);
      end else begin
        plc_pulse <= 1'b0;
      end
    end
  end

  assign ai_gt = analog_input_one > analog_input_two;

  always_comb begin
    next_switch = pick(switch_terminal_function_select, cond, plc_pulse, ai_gt, comm_lvl[ofs_pkg::COMM_SW]);
    next_relay = pick(relay_function_select, cond, plc_pulse, ai_gt, comm_lvl[ofs_pkg::COMM_RELAY]);
    next_oc2 = pick(second_oc_function_select, cond, plc_pulse, ai_gt, comm_lvl[ofs_pkg::COMM_OC2]);
  end

  // Every terminal level is a flop
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      switch_mode_terminal <= 1'b0;
      relay_output <= 1'b0;
      second_open_collector_output <= 1'b0;
      multiplexed_output_terminal <= 1'b0;
    end else if (ce) begin
      switch_mode_terminal <= next_switch;
      relay_output <= next_relay;
      second_open_collector_output <= next_oc2;
      multiplexed_output_terminal <= terminal_mode_selector ? next_switch : pulse_mode_terminal;
    end
  end

  // Cycles since the pulse level last moved, for checking
  logic [ofs_pkg::HW-1:0] hold_cnt;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      hold_cnt <= '0;
    end else if (ce) begin
      hold_cnt <= (hold_cnt == '1) ? hold_cnt : hold_cnt + 16'h0001;
      if (terminal_mode_selector || pulse_mode_terminal != $past(pulse_mode_terminal)) begin
        hold_cnt <= '0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!srst_n);

  a_mode_pulse_path: assert property (
    ce && !terminal_mode_selector |=> multiplexed_output_terminal == $past(pulse_mode_terminal)
  ) else $error("pulse mode not on terminal");

  a_mode_switch_path: assert property (
    ce && terminal_mode_selector |=> multiplexed_output_terminal == $past(next_switch)
  ) else $error("switch mode not on terminal");

  a_pulse_rate_cap: assert property (
    ce && !terminal_mode_selector && $changed(pulse_mode_terminal) && hold_cnt != '0
    |-> $past(hold_cnt) >= ofs_pkg::HW'(ofs_pkg::PULSE_MIN_HALF - 2)
  ) else $error("pulse edge too soon");

  a_sel_in_range: assert property (
    switch_terminal_function_select <= ofs_pkg::FN_MAX && relay_function_select <= ofs_pkg::FN_MAX
    && second_oc_function_select <= ofs_pkg::FN_MAX
  ) else $error("selector out of range");

  a_code_none_off: assert property (
    ce && relay_function_select == ofs_pkg::FN_NONE |=> !relay_output
  ) else $error("code 0 drove relay");

  a_zero_speed_tie: assert property (
    ce && relay_function_select == ofs_pkg::FN_ZERO |=> relay_output == $past(cond.running && cond.freq_zero)
  ) else $error("zero speed level wrong");

  a_lower_stopped_off: assert property (
    ce && second_oc_function_select == ofs_pkg::FN_LOWER && !cond.running |=> !second_open_collector_output
  ) else $error("lower limit on while stopped");

  a_plc_pulse_start: assert property (
    ce && cond.plc_cycle_done |=> plc_pulse && plc_cnt == PCW'(PLC_CYC - 1)
  ) else $error("sequencer pulse not started");

  a_plc_pulse_end: assert property (
    ce && plc_pulse && plc_cnt == '0 && !cond.plc_cycle_done |=> !plc_pulse
  ) else $error("sequencer pulse overran");

  a_host_level: assert property (
    ce && switch_terminal_function_select == ofs_pkg::FN_COMM
    |=> switch_mode_terminal == $past(comm_lvl[ofs_pkg::COMM_SW])
  ) else $error("host level not followed");

  a_reserved_off: assert property (
    ce && second_oc_function_select > ofs_pkg::FN_COMM |=> !second_open_collector_output
  ) else $error("reserved code drove output");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped");
endmodule : ofs_top

`default_nettype wire

// ### ofs_term_watch.sv
// Equipment-side watcher that times the multiplexed terminal's pulse half periods
`timescale 1ns/100ps
`default_nettype none
module ofs_term_watch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic terminal,
  output logic [15:0] half_cycles,
  output logic [7:0] edge_count
);
  logic last;
  logic [15:0] run;
  // Counts clocks between level changes, as a frequency meter on the pin would
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      run <= 16'h0001;
      half_cycles <= 16'h0000;
      edge_count <= 8'h00;
    end else if (terminal != last) begin
      last <= terminal;
      half_cycles <= run;
      run <= 16'h0001;
      edge_count <= edge_count + 8'h01;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule : ofs_term_watch
`default_nettype wire

// ### tb_output_terminal_function_select.sv
// Self-checking bench for the output terminal function select block
`timescale 1ns/100ps
`default_nettype none
module tb_output_terminal_function_select;
  localparam int PLC_SIM = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mux_pin, relay_pin, oc_pin;
  logic [1:0] bresp, rresp;
  ofs_pkg::ofs_cond_t cond = '0;
  logic [11:0] ai1 = 12'h000, ai2 = 12'h000;
  logic [15:0] half_cycles;
  logic [7:0] edge_count;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0;
  int checks_done = 0;

  always #12.5 clk_sys = ~clk_sys;

  ofs_top #(.AIW(12), .PLC_CYC(PLC_SIM)) ofs_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cond(cond), .analog_input_one(ai1), .analog_input_two(ai2),
    .multiplexed_output_terminal(mux_pin), .relay_output(relay_pin), .second_open_collector_output(oc_pin));

  ofs_term_watch ofs_term_watch_inst (.clk_sys(clk_sys), .rst_n(rst_n), .terminal(mux_pin),
    .half_cycles(half_cycles), .edge_count(edge_count));

  task automatic check(input string name, input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  // Level a selector code should give for a set of drive conditions
  function automatic logic fn_level(input logic [5:0] code, input ofs_pkg::ofs_cond_t c, input logic gt,
                                    input logic host);
    logic [20:0] v;
    v = {host, c.under_volt, c.lower_hit & c.running, c.upper_hit, gt,
         c.supply_ok & ~c.fault_seen & c.operable, c.speed_mode & c.torque_at_lim & c.stall,
         c.set_beyond_lim & c.out_at_lim, c.run_time_over, 1'b0, c.len_over,
         c.cnt_spec_hit, c.cnt_set_hit, c.drive_ovl_pre, c.motor_ovl_pre,
         c.running & c.freq_zero, c.freq_arrive, c.frequency_level_detect_one,
         c.fault_stop, c.running, 1'b0};
    fn_level = (code <= ofs_pkg::FN_COMM) ? v[code[4:0]] : 1'b0;
  endfunction : fn_level

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [33:0] exp);
    @(posedge clk_sys);
    rq.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_sys);
    rready <= 1'b0;
  endtask : axi_read

  task automatic wait_toggles;
    logic [7:0] e0;
    e0 = edge_count;
    for (int i = 0; i < 2000 && (edge_count - e0) < 8'h03; i++) @(posedge clk_sys);
    // A pin that never moves counts as a mismatch, not a silent pass
    check("toggles", {33'h0, (edge_count - e0) >= 8'h03}, 34'h1);
  endtask : wait_toggles

  // Responses are compared against the oldest noted expectation
  always @(posedge clk_sys) begin
    if (bvalid === 1'b1 && bready === 1'b1) check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1) check("rdata", {rresp, rdata}, rq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end

  initial begin
    logic [31:0] rnd;
    logic [5:0] code;
    logic e_sw, e_rl, e_oc, gt;
    ofs_pkg::ofs_cond_t c;
    int n;
    rnd = 32'h5408;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    axi_read(ofs_pkg::ADDR_MODE, {ofs_pkg::RESP_OKAY, 32'h0});
    axi_read(ofs_pkg::ADDR_SW_SEL, {ofs_pkg::RESP_OKAY, 32'h0});
    axi_read(ofs_pkg::ADDR_RELAY_SEL, {ofs_pkg::RESP_OKAY, 32'h2});
    axi_read(ofs_pkg::ADDR_OC2_SEL, {ofs_pkg::RESP_OKAY, 32'h0});
    axi_read(ofs_pkg::ADDR_HALF, {ofs_pkg::RESP_OKAY, 32'h00C8});
    axi_write(8'h1C, 32'h1, ofs_pkg::RESP_SLVERR);
    axi_read(8'h1C, {ofs_pkg::RESP_SLVERR, 32'h0});
    axi_write(ofs_pkg::ADDR_MODE, 32'h1, ofs_pkg::RESP_OKAY);
    for (int k = 0; k <= 42; k++) begin
      code = k[5:0];
      axi_write(ofs_pkg::ADDR_SW_SEL, {26'h0, code}, ofs_pkg::RESP_OKAY);
      axi_write(ofs_pkg::ADDR_RELAY_SEL, {26'h0, code}, ofs_pkg::RESP_OKAY);
      axi_write(ofs_pkg::ADDR_OC2_SEL, {26'h0, code}, ofs_pkg::RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
        rnd = lfsr_next(rnd);
        c = ofs_pkg::ofs_cond_t'(rnd[22:0]);
        c.plc_cycle_done = 1'b0;
        gt = rnd[31:20] > rnd[11:0];
        cond <= c;
        ai1 <= rnd[31:20];
        ai2 <= rnd[11:0];
        axi_write(ofs_pkg::ADDR_COMM, {29'h0, rnd[25:23]}, ofs_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        e_sw = fn_level(code, c, gt, rnd[23]);
        e_rl = fn_level(code, c, gt, rnd[24]);
        e_oc = fn_level(code, c, gt, rnd[25]);
        check("switch_pin", {33'h0, mux_pin}, {33'h0, e_sw});
        check("relay_pin", {33'h0, relay_pin}, {33'h0, e_rl});
        check("oc_pin", {33'h0, oc_pin}, {33'h0, e_oc});
        axi_read(ofs_pkg::ADDR_STATUS, {ofs_pkg::RESP_OKAY, 27'h0, 1'b0, e_oc, e_rl, e_sw, 1'b0});
      end
    end
    // Out-of-range code must leave the last selector in place
    axi_write(ofs_pkg::ADDR_SW_SEL, 32'h2B, ofs_pkg::RESP_OKAY);
    axi_read(ofs_pkg::ADDR_SW_SEL, {ofs_pkg::RESP_OKAY, 32'h2A});
    c = '0;
    cond <= c;
    axi_write(ofs_pkg::ADDR_RELAY_SEL, {26'h0, ofs_pkg::FN_PLC}, ofs_pkg::RESP_OKAY);
    c.plc_cycle_done = 1'b1;
    cond <= c;
    @(posedge clk_sys);
    c.plc_cycle_done = 1'b0;
    cond <= c;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      if (relay_pin === 1'b1) n++;
    end
    check("plc_width", 34'(n), 34'(PLC_SIM));
    axi_write(ofs_pkg::ADDR_MODE, 32'h0, ofs_pkg::RESP_OKAY);
    wait_toggles();
    check("half_default", {18'h0, half_cycles}, 34'h000C8);
    axi_write(ofs_pkg::ADDR_HALF, 32'h0032, ofs_pkg::RESP_OKAY);
    axi_read(ofs_pkg::ADDR_HALF, {ofs_pkg::RESP_OKAY, 32'h00C8});
    wait_toggles();
    check("half_floor", {18'h0, half_cycles}, 34'h000C8);
    axi_write(ofs_pkg::ADDR_HALF, 32'h012C, ofs_pkg::RESP_OKAY);
    wait_toggles();
    check("half_slow", {18'h0, half_cycles}, 34'h0012C);
    // Enable low must freeze the pulse, so the pin count stays put
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    n = edge_count;
    repeat (400) @(posedge clk_sys);
    check("ce_freeze", 34'(edge_count), 34'(n));
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
endmodule : tb_output_terminal_function_select
`default_nettype wire
